//--- design/opb_consts.svh
`ifndef OPB_CONSTS_SVH
`define OPB_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and self-timed operation times
// ----------------------------------------------------------------------
`define OPB_CLK_PERIOD_NS 4
`define OPB_OTP_PROGRAM_TIME_NS 200000
`define OPB_PAGE_COPY_TIME_NS 200000
`define OPB_PAGE_COMPARE_TIME_NS 200000
`define OPB_ERASE_PROGRAM_TIME_NS 20000000
`define OPB_TIMER_W 24

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OPB_OPC_OTP_PROG 8'h9B
`define OPB_OPC_OTP_READ 8'h77
`define OPB_OPC_XFER_B1 8'h53
`define OPB_OPC_XFER_B2 8'h55
`define OPB_OPC_CMP_B1 8'h60
`define OPB_OPC_CMP_B2 8'h61
`define OPB_OPC_REWR_B1 8'h58
`define OPB_OPC_REWR_B2 8'h59
`define OPB_OPC_STATUS 8'hD7
`define OPB_HDR_FILL 8'h00

// ----------------------------------------------------------------------
// frame layout and field positions
// ----------------------------------------------------------------------
`define OPB_HDR_BYTES 3'h4
`define OPB_LAST_BIT 3'h7
`define OPB_PA528_HI 22
`define OPB_PA528_LO 10
`define OPB_PA512_HI 21
`define OPB_PA512_LO 9
`define OPB_OTP_HALF 64
`define OPB_DENSITY_CODE 4'hD
`define OPB_PROTECT_OFF 1'b0
`define OPB_STAT2_LOW 7'h00

`endif

//--- design/opb_pkg.sv
package opb_pkg;

  // sequencer state
  typedef enum logic [0:0] {
    SEQ_READY = 1'b0,
    SEQ_BUSY = 1'b1
  } opb_seq_e;

  // self-timed operation kinds
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_OTP = 3'b001,
    OP_XFER = 3'b010,
    OP_CMP = 3'b011,
    OP_REWR = 3'b100
  } opb_op_e;

  // request to the main array
  typedef struct packed {
    logic valid;
    opb_op_e op;
    logic buf2;
    logic [12:0] page;
  } opb_array_cmd_s;

  // serial pins, synchronised
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } opb_spi_s;

endpackage

//--- design/opb_otp_page_ops.sv
`timescale 1ns/1ps
`include "opb_consts.svh"
// Operation
// RULE_01: 128-byte security area: bytes 0-63 user OTP, 64-127 factory unique.
// RULE_02: user half programs once only, never erased or rewritten afterwards; here a reset with I_OTP_DONE_STRAP low permits another program.
// RULE_03: factory half is fixed; no command path writes it.
// RULE_04: user half programs without any erase step first.
// RULE_05: host sends 9B 00 00 00 then 64 data bytes, chip select low.
// RULE_06: chip select rise starts self-timed OTP program, busy throughout.
// RULE_07: host supplies all 64 bytes; missing bytes are undefined.
// RULE_08: beyond 64 data bytes the write pointer wraps to location 0.
// RULE_09: OTP program uses buffer 1 as working storage, overwriting it.
// RULE_10: opcode 77 plus three dummies, then area bytes out from location 0.
// RULE_11: past the last byte data undefined; chip select rise floats output.
// RULE_12: host sends 53/55 plus three address bytes for page-to-buffer copy.
// RULE_13: 528 mode address: one dummy bit, 13-bit page, ten dummy bits.
// RULE_14: 512 mode address: two dummy bits, page in bits 21-9, nine dummies.
// RULE_15: latch only while chip select low; copy starts on rise, busy.
// RULE_16: host sends 60/61 plus three address bytes for page compare.
// RULE_17: compare on chip select rise, busy for compare time, result bit 6.
// RULE_18: host sends 58/59 plus three address bytes for page refresh.
// RULE_19: refresh copies page to buffer, reprograms it, busy until done.
// RULE_20: host refreshes every page within 50,000 sector erase/programs.
// RULE_21: compare bit is 0 on match and 1 on any difference.
// RULE_22: status bit 7 is 0 while busy, 1 when ready.
// RULE_23: status read with D7 is accepted at any time, even while busy.
// RULE_24: nonvolatile programmed flag blocks any later OTP program command; here locked_reg is a register reloaded from I_OTP_DONE_STRAP at reset.
// RULE_25: page address layout follows the stored page-size setting.
module opb_otp_page_ops
  import opb_pkg::*;
#(
  parameter int P_OTP_PROG_CYC =
    `OPB_OTP_PROGRAM_TIME_NS / `OPB_CLK_PERIOD_NS,
  parameter int P_COPY_CYC = `OPB_PAGE_COPY_TIME_NS / `OPB_CLK_PERIOD_NS,
  parameter int P_CMP_CYC = `OPB_PAGE_COMPARE_TIME_NS / `OPB_CLK_PERIOD_NS,
  parameter int P_REWR_CYC =
    `OPB_ERASE_PROGRAM_TIME_NS / `OPB_CLK_PERIOD_NS,
  parameter logic [7:0] P_UID_SEED = 8'hA5 // arbitrary value
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // serial link pins
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_SI,
  output logic O_SO,
  output logic O_SO_OE,
  // configuration straps
  input wire logic I_PAGE_512,
  input wire logic I_OTP_DONE_STRAP,
  // main array
  output opb_array_cmd_s O_ARRAY_CMD,
  input wire logic I_ARRAY_DIFF,
  // buffer 1 write port
  output logic O_BUF1_WE,
  output logic [5:0] O_BUF1_ADDR,
  output logic [7:0] O_BUF1_DATA,
  // status
  output logic O_READY,
  output logic O_COMP_DIFF,
  output logic O_OTP_LOCKED
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  opb_spi_s s1_reg, s2_reg;
  logic sck_d_reg, cs_d_reg, cfg1_reg, cfg2_reg;

  // two flops per pin before any logic reads it
  always_ff @(posedge I_REF_CLK) begin
    s1_reg <= '{sck: I_SCK, cs_n: I_CS_N, si: I_SI};
    s2_reg <= s1_reg;
    sck_d_reg <= s2_reg.sck;
    cs_d_reg <= s2_reg.cs_n;
    cfg1_reg <= I_PAGE_512;
    cfg2_reg <= cfg1_reg;
  end

  logic sck_rise, sck_fall, cs_low, cs_fall, cs_rise;
  assign sck_rise = s2_reg.sck & ~sck_d_reg;
  assign sck_fall = ~s2_reg.sck & sck_d_reg;
  assign cs_low = ~s2_reg.cs_n;
  assign cs_fall = ~s2_reg.cs_n & cs_d_reg;
  assign cs_rise = s2_reg.cs_n & ~cs_d_reg;

  // ----------------------------------------------------------------------
  // security area storage
  // ----------------------------------------------------------------------
  logic [7:0] user_mem [`OPB_OTP_HALF];
  logic [7:0] stage_mem [`OPB_OTP_HALF];
  logic [7:0] uid_rom [`OPB_OTP_HALF];
  logic commit;

  // factory half: constant per device, no write path
  genvar gi;
  generate
    for (gi = 0; gi < `OPB_OTP_HALF; gi++) begin : g_uid
      assign uid_rom[gi] = P_UID_SEED ^ 8'(gi * 37); // RULE_01 RULE_03
    end
  endgenerate

  // ----------------------------------------------------------------------
  // serial shifter and command capture
  // ----------------------------------------------------------------------
  logic [2:0] bit_cnt_reg, bit_cnt_next, byte_cnt_reg, byte_cnt_next;
  logic [7:0] rx_reg, rx_next, opc_reg, opc_next, tx_reg, tx_next;
  logic [23:0] addr_reg, addr_next;
  logic hdr_ok_reg, hdr_ok_next, so_reg, so_next, oe_reg, oe_next;
  logic st_sel_reg, st_sel_next;
  logic [5:0] wptr_reg, wptr_next;
  logic [6:0] rptr_reg, rptr_next;
  logic [7:0] rx_byte, stat1, stat2, rd_byte;
  logic stage_we;
  opb_seq_e seq_reg, seq_next;
  logic comp_reg, comp_next, locked_reg, locked_next;

  assign rx_byte = {rx_reg[6:0], s2_reg.si};
  assign stat1 = {seq_reg == SEQ_READY, comp_reg, `OPB_DENSITY_CODE,
                  `OPB_PROTECT_OFF, cfg2_reg}; // RULE_21 RULE_22
  assign stat2 = {seq_reg == SEQ_READY, `OPB_STAT2_LOW}; // RULE_22
  assign rd_byte = rptr_reg[6] ? uid_rom[rptr_reg[5:0]]
                               : user_mem[rptr_reg[5:0]]; // RULE_10

  // next state of the shifter
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    rx_next = rx_reg;
    opc_next = opc_reg;
    addr_next = addr_reg;
    hdr_ok_next = hdr_ok_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    tx_next = tx_reg;
    so_next = so_reg;
    oe_next = oe_reg;
    st_sel_next = st_sel_reg;
    stage_we = 1'b0;
    if (cs_fall) begin
      bit_cnt_next = '0;
      byte_cnt_next = '0;
      hdr_ok_next = 1'b1;
      wptr_next = '0;
      rptr_next = '0;
      st_sel_next = 1'b0;
    end else if (cs_low && sck_rise) begin // RULE_15
      rx_next = rx_byte;
      bit_cnt_next = bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == `OPB_LAST_BIT) begin
        if (byte_cnt_reg != `OPB_HDR_BYTES) begin
          byte_cnt_next = byte_cnt_reg + 3'h1;
        end
        if (byte_cnt_reg == 3'h0) begin
          opc_next = rx_byte;
        end else if (byte_cnt_reg != `OPB_HDR_BYTES) begin
          addr_next = {addr_reg[15:0], rx_byte};
          if (rx_byte != `OPB_HDR_FILL) begin
            hdr_ok_next = 1'b0; // RULE_05
          end
        end else if (opc_reg == `OPB_OPC_OTP_PROG && hdr_ok_reg &&
                     !locked_reg && seq_reg == SEQ_READY) begin // RULE_24
          stage_we = 1'b1; // RULE_09
          wptr_next = wptr_reg + 6'h1; // RULE_08
        end
      end
    end
    // output: on status reads load a byte at each byte boundary after the opcode, on OTP reads after the four header bytes, else shift
    if (!cs_low) begin
      oe_next = 1'b0; // RULE_11
    end else if (sck_fall) begin
      if (bit_cnt_reg == 3'h0 && byte_cnt_reg != 3'h0 &&
          opc_reg == `OPB_OPC_STATUS) begin // RULE_23
        tx_next = st_sel_reg ? stat2 : stat1;
        st_sel_next = ~st_sel_reg;
        so_next = tx_next[7];
        oe_next = 1'b1;
      end else if (bit_cnt_reg == 3'h0 && byte_cnt_reg == `OPB_HDR_BYTES &&
                   opc_reg == `OPB_OPC_OTP_READ) begin
        tx_next = rd_byte; // RULE_10 RULE_11
        rptr_next = rptr_reg + 7'h1;
        so_next = tx_next[7];
        oe_next = 1'b1;
      end else if (oe_reg) begin
        tx_next = {tx_reg[6:0], 1'b0};
        so_next = tx_reg[6];
      end
    end
  end

  // shifter registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      rx_reg <= '0;
      opc_reg <= '0;
      addr_reg <= '0;
      hdr_ok_reg <= 1'b0;
      wptr_reg <= '0;
      rptr_reg <= '0;
      tx_reg <= '0;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
      st_sel_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      rx_reg <= rx_next;
      opc_reg <= opc_next;
      addr_reg <= addr_next;
      hdr_ok_reg <= hdr_ok_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      tx_reg <= tx_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
      st_sel_reg <= st_sel_next;
    end
  end

  // staging memory, mirrored to buffer 1
  always_ff @(posedge I_REF_CLK) begin
    if (stage_we) begin
      stage_mem[wptr_reg] <= rx_byte; // RULE_09
    end
    if (commit) begin
      user_mem <= stage_mem; // RULE_02 RULE_04
    end
  end

  // ----------------------------------------------------------------------
  // self-timed sequencer
  // ----------------------------------------------------------------------
  opb_op_e op_reg, op_next;
  logic [`OPB_TIMER_W-1:0] tmr_reg, tmr_next;
  opb_array_cmd_s cmd_reg, cmd_next;
  logic [12:0] page;
  logic full_hdr;

  assign page = cfg2_reg ? addr_reg[`OPB_PA512_HI:`OPB_PA512_LO]
                         : addr_reg[`OPB_PA528_HI:`OPB_PA528_LO];
  assign full_hdr = byte_cnt_reg == `OPB_HDR_BYTES; // RULE_13 RULE_14 RULE_25

  // launch on chip select rise, count down, finish
  always_comb begin
    seq_next = seq_reg;
    op_next = op_reg;
    tmr_next = tmr_reg;
    comp_next = comp_reg;
    locked_next = locked_reg;
    cmd_next = cmd_reg;
    cmd_next.valid = 1'b0;
    commit = 1'b0;
    case (seq_reg)
      SEQ_READY: begin
        if (cs_rise && full_hdr) begin
          cmd_next.page = page;
          cmd_next.buf2 = opc_reg[0];
          case (opc_reg)
            `OPB_OPC_OTP_PROG: begin
              if (hdr_ok_reg && !locked_reg) begin // RULE_24
                op_next = OP_OTP;
                tmr_next = `OPB_TIMER_W'(P_OTP_PROG_CYC - 1); // RULE_06
                locked_next = 1'b1; // RULE_02
              end
            end
            `OPB_OPC_XFER_B1, `OPB_OPC_XFER_B2: begin
              cmd_next.buf2 = opc_reg == `OPB_OPC_XFER_B2;
              op_next = OP_XFER;
              tmr_next = `OPB_TIMER_W'(P_COPY_CYC - 1); // RULE_15
            end
            `OPB_OPC_CMP_B1, `OPB_OPC_CMP_B2: begin
              op_next = OP_CMP;
              tmr_next = `OPB_TIMER_W'(P_CMP_CYC - 1); // RULE_17
            end
            `OPB_OPC_REWR_B1, `OPB_OPC_REWR_B2: begin
              op_next = OP_REWR;
              tmr_next = `OPB_TIMER_W'(P_REWR_CYC - 1); // RULE_19
            end
            default: op_next = OP_NONE;
          endcase
          if (op_next != OP_NONE) begin
            seq_next = SEQ_BUSY;
            cmd_next.valid = op_next != OP_OTP;
            cmd_next.op = op_next;
          end
        end
      end
      SEQ_BUSY: begin
        if (tmr_reg == '0) begin
          seq_next = SEQ_READY;
          op_next = OP_NONE;
          if (op_reg == OP_CMP) begin
            comp_next = I_ARRAY_DIFF; // RULE_17 RULE_21
          end
          commit = op_reg == OP_OTP; // RULE_06
        end else begin
          tmr_next = tmr_reg - `OPB_TIMER_W'(1);
        end
      end
      default: seq_next = SEQ_READY;
    endcase
  end

  // sequencer registers; the programmed flag is loaded from its strap
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      seq_reg <= SEQ_READY;
      op_reg <= OP_NONE;
      tmr_reg <= '0;
      comp_reg <= 1'b0;
      locked_reg <= I_OTP_DONE_STRAP; // RULE_24
      cmd_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      op_reg <= op_next;
      tmr_reg <= tmr_next;
      comp_reg <= comp_next;
      locked_reg <= locked_next;
      cmd_reg <= cmd_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign O_SO = so_reg;
  assign O_SO_OE = oe_reg;
  assign O_ARRAY_CMD = cmd_reg;
  assign O_BUF1_WE = stage_we;
  assign O_BUF1_ADDR = wptr_reg;
  assign O_BUF1_DATA = rx_byte;
  assign O_READY = seq_reg == SEQ_READY;
  assign O_COMP_DIFF = comp_reg;
  assign O_OTP_LOCKED = locked_reg;

endmodule

//--- sim/opb_otp_page_ops_asserts.sv
`timescale 1ns/1ps
module opb_otp_page_ops_asserts
  import opb_pkg::*;
#(
  parameter int P_OTP_PROG_CYC = 20,
  parameter int P_COPY_CYC = 20,
  parameter int P_CMP_CYC = 20,
  parameter int P_REWR_CYC = 20
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // watched pins
  input wire logic I_CS_N,
  input wire logic I_ARRAY_DIFF,
  input wire opb_array_cmd_s O_ARRAY_CMD,
  input wire logic O_SO_OE,
  input wire logic O_BUF1_WE,
  input wire logic O_READY,
  input wire logic O_COMP_DIFF,
  input wire logic O_OTP_LOCKED
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  opb_op_e kind_reg, kind_next;
  logic ready_reg;
  logic [23:0] cnt_reg, cnt_next;
  int exp_len;
  // track the running operation kind and its busy length
  always_comb begin
    kind_next = kind_reg;
    if (ready_reg && !O_READY) begin
      kind_next = O_ARRAY_CMD.valid ? O_ARRAY_CMD.op : OP_OTP;
    end
    cnt_next = O_READY ? 24'h0 : cnt_reg + 24'h1;
    case (kind_reg)
      OP_XFER: exp_len = P_COPY_CYC;
      OP_CMP: exp_len = P_CMP_CYC;
      OP_REWR: exp_len = P_REWR_CYC;
      default: exp_len = P_OTP_PROG_CYC;
    endcase
  end
  // helper registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      kind_reg <= OP_NONE;
      ready_reg <= 1'b1;
      cnt_reg <= 24'h0;
    end else begin
      kind_reg <= kind_next;
      ready_reg <= O_READY;
      cnt_reg <= cnt_next;
    end
  end
  a_busy_len: assert property ($rose(O_READY) |->
    cnt_reg == 24'(exp_len)) else $error("busy length off");
  a_cmp_result: assert property (
    $rose(O_READY) && kind_reg == OP_CMP |->
    O_COMP_DIFF == $past(I_ARRAY_DIFF)) else $error("compare bit wrong");
  a_comp_hold: assert property (!$rose(O_READY) |->
    $stable(O_COMP_DIFF)) else $error("compare bit moved");
  a_cmd_pulse: assert property (O_ARRAY_CMD.valid |=>
    !O_ARRAY_CMD.valid) else $error("request longer than one cycle");
  a_cmd_launch: assert property (O_ARRAY_CMD.valid |->
    $fell(O_READY)) else $error("request without busy");
  a_launch_cs: assert property ($fell(O_READY) |->
    I_CS_N && $past(I_CS_N)) else $error("launch while selected");
  a_so_float: assert property (I_CS_N [*6] |-> !O_SO_OE)
    else $error("output driven while deselected");
  a_lock_keep: assert property (O_OTP_LOCKED |=> O_OTP_LOCKED)
    else $error("lock flag cleared");
  a_lock_launch: assert property ($rose(O_OTP_LOCKED) |->
    $fell(O_READY) && !O_ARRAY_CMD.valid) else $error("lock without launch");
  a_we_ready: assert property (O_BUF1_WE |->
    O_READY && !O_OTP_LOCKED) else $error("buffer write refused case");
endmodule

//--- sim/opb_spi_host.sv
`timescale 1ns/1ps
module opb_spi_host (
  // reference clock and returned data
  input wire logic i_clk,
  input wire logic i_so,
  // serial pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  // idle pins
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // select stays low for the whole frame
  task automatic start;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  // one byte msb first; data sampled just before the rising edge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si = d[i];
      repeat (4) @(negedge i_clk);
      q[i] = i_so;
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
    end
  endtask
  // deselect after the last byte; released data line flips
  task automatic stop;
    o_sck = 1'b0;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

//--- sim/test_opb_otp_page_ops.sv
`timescale 1ns/1ps
module test_opb_otp_page_ops;
  import opb_pkg::*;
  localparam int CYC = 20;
  localparam int REWR = 900;
  localparam logic [7:0] SEED = 8'h5A; // arbitrary value
  logic clk, rst, sck, cs_n, si, so, so_oe, pg512, diff, we;
  logic ready, comp, locked, strap;
  logic [5:0] waddr;
  logic [7:0] wdata, rx;
  logic [7:0] wmem [64];
  opb_array_cmd_s cmd_o, last_cmd;
  int n_cmd = 0;
  int n_we = 0;
  int errors = 0;
  int n_tests = 0;
  opb_otp_page_ops #(.P_OTP_PROG_CYC(CYC), .P_COPY_CYC(CYC),
    .P_CMP_CYC(CYC), .P_REWR_CYC(REWR), .P_UID_SEED(SEED))
  opb_otp_page_ops_i (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_SCK(sck),
    .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe),
    .I_PAGE_512(pg512), .I_OTP_DONE_STRAP(strap), .O_ARRAY_CMD(cmd_o),
    .I_ARRAY_DIFF(diff), .O_BUF1_WE(we), .O_BUF1_ADDR(waddr),
    .O_BUF1_DATA(wdata), .O_READY(ready), .O_COMP_DIFF(comp),
    .O_OTP_LOCKED(locked));
  opb_spi_host opb_spi_host_i (.i_clk(clk), .i_so(so), .o_sck(sck),
    .o_cs_n(cs_n), .o_si(si));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // record array requests and buffer 1 writes
  always @(posedge clk) begin
    if (cmd_o.valid) begin
      last_cmd <= cmd_o;
      n_cmd <= n_cmd + 1;
    end
    if (we) begin
      wmem[waddr] <= wdata;
      n_we <= n_we + 1;
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) begin
      errors++;
      final_report;
    end
  endtask
  // reset for two cycles with the programmed strap set to s
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // opcode plus three address bytes; frame left open
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    opb_spi_host_i.start;
    opb_spi_host_i.xfer(op, rx);
    opb_spi_host_i.xfer(a[23:16], rx);
    opb_spi_host_i.xfer(a[15:8], rx);
    opb_spi_host_i.xfer(a[7:0], rx);
  endtask
  // every page opcode in both address layouts
  task automatic t_page;
    logic [7:0] ops [6] = '{8'h53, 8'h55, 8'h60,
      8'h61, 8'h58, 8'h59};
    logic [12:0] pg;
    for (int m = 0; m < 2; m++) begin
      for (int j = 0; j < 6; j++) begin
        pg = 13'h1ABC ^ 13'(j * 9);
        pg512 = m[0];
        diff = j[0] ^ m[0];
        cmd(ops[j], m ? {2'b11, pg, 9'h1FF} : {1'b1, pg, 10'h3FF});
        opb_spi_host_i.stop;
        wait_rdy;
        chk("op", 24'(last_cmd.op), 24'(j / 2 + 2));
        chk("buf2", 24'(last_cmd.buf2), 24'(j % 2));
        chk("page", 24'(last_cmd.page), 24'(pg));
        if (j / 2 == 1) chk("comp", 24'(comp), 24'(diff));
      end
    end
  endtask
  // status read and refused command while a rewrite runs
  task automatic t_busy;
    int base;
    base = n_cmd + 1;
    cmd(8'h58, 24'h0);
    opb_spi_host_i.stop;
    opb_spi_host_i.start;
    opb_spi_host_i.xfer(8'hD7, rx);
    opb_spi_host_i.xfer(8'h00, rx);
    chk("stat", 24'(rx), {16'h0, 1'b0, 1'b0, 5'h1A, pg512});
    opb_spi_host_i.xfer(8'h00, rx);
    chk("stat2", 24'(rx), 24'h0);
    opb_spi_host_i.stop;
    cmd(8'h53, 24'h0);
    opb_spi_host_i.stop;
    wait_rdy;
    chk("refused", 24'(n_cmd), 24'(base));
  endtask
  // strapped lock after a mid-run reset refuses a program
  task automatic t_strap;
    int nw;
    nw = n_we;
    do_reset(1'b1);
    chk("strap", 24'(locked), 24'h1);
    cmd(8'h9B, 24'h0);
    opb_spi_host_i.xfer(8'h11, rx);
    opb_spi_host_i.stop;
    chk("nwe0", 24'(n_we), 24'(nw));
    chk("idle", 24'(ready), 24'h1);
    do_reset(1'b0);
    chk("unstrap", 24'(locked), 24'h0);
  endtask
  // program with wrap, read back, then a refused second program
  task automatic t_otp;
    logic [7:0] e;
    cmd(8'h9B, 24'h0);
    for (int i = 0; i < 65; i++) begin
      opb_spi_host_i.xfer(8'(i) ^ 8'h3C, rx);
    end
    opb_spi_host_i.stop;
    chk("lock", 24'(locked), 24'h1);
    chk("nwe", 24'(n_we), 24'd65);
    chk("wrap", 24'(wmem[0]), 24'h7C);
    chk("buf1", 24'(wmem[63]), 24'h03);
    wait_rdy;
    cmd(8'h77, 24'h0);
    for (int i = 0; i < 128; i++) begin
      opb_spi_host_i.xfer(8'h00, rx);
      e = i < 64 ? 8'(i) ^ 8'h3C : SEED ^ 8'((i - 64) * 37);
      if (i == 0) e = 8'h7C;
      chk("area", 24'(rx), 24'(e));
    end
    opb_spi_host_i.stop;
    chk("oe", 24'(so_oe), 24'h0);
    cmd(8'h9B, 24'h0);
    opb_spi_host_i.xfer(8'hFF, rx);
    opb_spi_host_i.stop;
    chk("again", {22'h0, ready, 1'b0}, 24'h2);
    chk("nwe2", 24'(n_we), 24'd65);
  endtask
  // main sequence
  initial begin
    pg512 = 1'b0;
    diff = 1'b0;
    do_reset(1'b0);
    chk("rst", {20'h0, ready, comp, locked, so_oe}, 24'h8);
    t_page;
    t_busy;
    t_strap;
    t_otp;
    final_report;
  end
endmodule

bind opb_otp_page_ops opb_otp_page_ops_asserts #(
  .P_OTP_PROG_CYC(P_OTP_PROG_CYC), .P_COPY_CYC(P_COPY_CYC),
  .P_CMP_CYC(P_CMP_CYC), .P_REWR_CYC(P_REWR_CYC))
opb_otp_page_ops_asserts_i (.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
  .I_CS_N(I_CS_N), .I_ARRAY_DIFF(I_ARRAY_DIFF), .O_ARRAY_CMD(O_ARRAY_CMD),
  .O_SO_OE(O_SO_OE), .O_BUF1_WE(O_BUF1_WE), .O_READY(O_READY),
  .O_COMP_DIFF(O_COMP_DIFF), .O_OTP_LOCKED(O_OTP_LOCKED));
